// ### src/acl_consts.svh
// register indices, field positions, reset values and timing counts
`ifndef ACL_CONSTS_SVH
`define ACL_CONSTS_SVH

// register indices; byte address is four times the index
`define ACL_IDX_CTRL1 8'h0e
`define ACL_IDX_CTRL2 8'h0f
`define ACL_IDX_RES_HI 8'h20
`define ACL_IDX_RES_LO 8'h21
`define ACL_IDX_IRQ_STAT 8'h30
`define ACL_IDX_IRQ_MASK 8'h31

// reset values
`define ACL_RST_CTRL1 8'h10
`define ACL_RST_CTRL2 8'h00
`define ACL_RST_RES 8'h00

// conv_channel_start_ctrl fields
`define ACL_C1_START 7
`define ACL_C1_MODE_HI 6
`define ACL_C1_MODE_LO 5
`define ACL_C1_INDIS 4
`define ACL_C1_CH_HI 3

// conv_timing_ladder_ctrl fields
`define ACL_C2_LADDER 5
`define ACL_C2_TIME_HI 3
`define ACL_C2_TIME_LO 1
`define ACL_C2_KEEP_HI 5

// conv_result_low_status fields
`define ACL_R2_EOC 5
`define ACL_R2_BUSY 4

// conversion times in high_freq_osc_clock cycles (the module clock)
`define ACL_T_39 11'h027
`define ACL_T_78 11'h04e
`define ACL_T_156 11'h09c
`define ACL_T_312 11'h138
`define ACL_T_624 11'h270
`define ACL_T_1248 11'h4e0

// bus responses
`define ACL_RESP_OKAY 2'h0
`define ACL_RESP_SLVERR 2'h2

`endif

// ### src/acl_pkg.sv
// types shared by the converter control logic
package acl_pkg;

  typedef enum logic [1:0] {
    ACL_ST_IDLE = 2'b00,
    ACL_ST_CONV = 2'b01
  } acl_state_type;

  typedef enum logic [1:0] {
    ACL_MODE_OFF = 2'b00,
    ACL_MODE_SW = 2'b01,
    ACL_MODE_RSV = 2'b10,
    ACL_MODE_REPEAT = 2'b11
  } acl_mode_type;

  typedef enum logic [1:0] {
    ACL_PWR_RUN = 2'b00,
    ACL_PWR_STOP = 2'b01,
    ACL_PWR_SLOW = 2'b10,
    ACL_PWR_SLEEP = 2'b11
  } acl_pwr_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic [7:0] wdata;
  } acl_req_type;

  typedef struct packed {
    logic hit;
    logic [7:0] rdata;
  } acl_rsp_type;

  typedef struct packed {
    logic [2:0] channel;
    logic input_disable;
    logic ladder_connect;
    logic sample_start;
  } acl_ana_type;

endpackage

// ### src/acl_timer.sv
// conversion duration counter clocked by the module clock
module acl_timer #(
  parameter int CNT_W = 11
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control
  input wire logic load,
  input wire logic abort,
  input wire logic [CNT_W-1:0] count,
  // status
  output logic done
);
  logic [CNT_W-1:0] remain;
  logic run;

  if (CNT_W < 11) begin : g_cnt_check
    $error("acl_timer: CNT_W too small");
  end

  // done rises exactly count cycles after the load edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      remain <= '0;
      run <= 1'b0;
      done <= 1'b0;
    end else if (abort) begin
      run <= 1'b0;
      done <= 1'b0;
    end else if (load) begin
      remain <= count - 1'b1;
      run <= 1'b1;
      done <= 1'b0;
    end else if (run && remain == '0) begin
      run <= 1'b0;
      done <= 1'b1;
    end else begin
      remain <= run ? remain - 1'b1 : remain;
      done <= 1'b0;
    end
  end
endmodule // acl_timer

// ### src/acl_axil.sv
// axi4-lite slave front end, one write and one read at a time
`include "acl_consts.svh"
module acl_axil #(
  parameter int ADDR_W = 10
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // write address and data
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read address and data
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register side
  output acl_pkg::acl_req_type req,
  input wire acl_pkg::acl_rsp_type rsp
);
  logic [7:0] aw_idx;
  logic [7:0] ar_idx;
  logic [7:0] w_byte;
  logic w_lane;
  logic wr_go;
  logic rd_go;

  if (ADDR_W < 10) begin : g_addr_check
    $error("acl_axil: ADDR_W below 10");
  end

  assign wr_go = !awready && !wready && !bvalid && !req.wr;
  // a read strobe yields to a write strobe: both share req.idx
  assign rd_go = !arready && !rvalid && !req.rd && !wr_go;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_idx <= 8'h00;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_idx <= awaddr[9:2];
      end else if (bvalid && bready) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_byte <= wdata[7:0];
        w_lane <= wstrb[0];
      end else if (bvalid && bready) begin
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      arready <= 1'b1;
      ar_idx <= 8'h00;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      ar_idx <= araddr[9:2];
    end else if (rvalid && rready) begin
      arready <= 1'b1;
    end
  end

  // one-cycle strobes towards the register file
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      req <= '0;
    end else begin
      req.wr <= wr_go && w_lane;
      req.rd <= rd_go;
      req.idx <= rd_go ? ar_idx : aw_idx;
      req.wdata <= w_byte;
    end
  end

  // write response rises with the strobe; read response once the strobe has been seen by the registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp <= `ACL_RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= `ACL_RESP_OKAY;
      rdata <= 32'h0000_0000;
    end else begin
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= `ACL_RESP_OKAY;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      if (req.rd) begin
        rvalid <= 1'b1;
        rresp <= rsp.hit ? `ACL_RESP_OKAY : `ACL_RESP_SLVERR;
        rdata <= {24'h00_0000, rsp.rdata};
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule // acl_axil

// ### src/acl_control.sv
// converter control logic: registers, sequencing, interrupt
//
// Register access over AXI4-Lite is this design's own decision.
`include "acl_consts.svh"
module acl_control #(
  parameter int ADDR_W = 10,
  parameter int CNT_W = 11
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // power mode from the system controller
  input wire acl_pkg::acl_pwr_type power_mode,
  // analog side
  input wire logic [9:0] converted_value,
  output acl_pkg::acl_ana_type analog_ctrl,
  // interrupt
  output logic conversion_done_irq
);
  acl_pkg::acl_req_type req;
  acl_pkg::acl_rsp_type rsp;
  acl_pkg::acl_state_type state;
  acl_pkg::acl_state_type next_state;
  acl_pkg::acl_mode_type mode;

  // conv_channel_start_ctrl
  logic conversion_start_bit;
  logic [1:0] operating_mode_field;
  logic input_disable;
  logic [3:0] channel_select;
  // conv_timing_ladder_ctrl, bits 5..0 kept
  logic [5:0] timing_ctrl;
  // results and status
  logic [7:0] conv_result_high;
  logic [1:0] result_low;
  logic end_of_conversion_flag;
  logic conversion_busy_flag;
  logic irq_status;
  logic irq_mask;

  logic standby;
  logic wr_ok;
  logic start_now;
  logic finish;
  logic abort;
  logic restart;
  logic timer_done;
  logic [2:0] time_code;
  logic [CNT_W-1:0] conv_cycles;
  logic [CNT_W-1:0] load_count;
  logic read_high;

  if (CNT_W < 11) begin : g_cnt_check
    $error("acl_control: CNT_W too small");
  end
  if (ADDR_W < 10) begin : g_addr_check
    $error("acl_control: ADDR_W below 10");
  end

  acl_axil #(
    .ADDR_W(ADDR_W)
  ) u_bus (
    .clock(clock),
    .rst(rst),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .req(req),
    .rsp(rsp)
  );

  // stop, slow and sleep all count as standby
  assign standby = power_mode != acl_pkg::ACL_PWR_RUN;
  assign wr_ok = req.wr && !standby;
  assign mode = acl_pkg::acl_mode_type'(operating_mode_field);
  assign time_code = timing_ctrl[`ACL_C2_TIME_HI:`ACL_C2_TIME_LO];
  assign read_high = req.rd && req.idx == `ACL_IDX_RES_HI;

  // reserved mode code never starts a conversion
  assign start_now = state == acl_pkg::ACL_ST_IDLE && conversion_start_bit
    && (mode == acl_pkg::ACL_MODE_SW || mode == acl_pkg::ACL_MODE_REPEAT)
    && !standby;
  // dropping to the off mode stops at once, nothing stored
  assign abort = state == acl_pkg::ACL_ST_CONV
    && (standby || mode == acl_pkg::ACL_MODE_OFF);
  assign finish = state == acl_pkg::ACL_ST_CONV && timer_done && !abort;
  assign restart = finish && mode == acl_pkg::ACL_MODE_REPEAT;

  // reserved codes fall back to the longest time, the safe side
  always_comb begin
    case (time_code)
      3'h0: conv_cycles = `ACL_T_39;
      3'h2: conv_cycles = `ACL_T_78;
      3'h3: conv_cycles = `ACL_T_156;
      3'h4: conv_cycles = `ACL_T_312;
      3'h5: conv_cycles = `ACL_T_624;
      3'h6: conv_cycles = `ACL_T_1248;
      default: conv_cycles = `ACL_T_1248;
    endcase
  end

  // done leads the store by one edge, so the store lands exactly
  // the selected count after the start edge
  assign load_count = conv_cycles - CNT_W'(1);

  acl_timer #(
    .CNT_W(CNT_W)
  ) u_timer (
    .clock(clock),
    .rst(rst),
    .load(start_now || restart),
    .abort(abort),
    .count(load_count),
    .done(timer_done)
  );

  always_comb begin
    case (state)
      acl_pkg::ACL_ST_IDLE:
        next_state = start_now ? acl_pkg::ACL_ST_CONV : acl_pkg::ACL_ST_IDLE;
      acl_pkg::ACL_ST_CONV: begin
        if (abort || (finish && !restart)) begin
          next_state = acl_pkg::ACL_ST_IDLE;
        end else begin
          next_state = acl_pkg::ACL_ST_CONV;
        end
      end
      default: next_state = acl_pkg::ACL_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= acl_pkg::ACL_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // channel, input control and mode; standby forces reset values
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      operating_mode_field <= 2'h0;
      input_disable <= 1'b1;
      channel_select <= 4'h0;
    end else if (standby) begin
      operating_mode_field <= 2'h0;
      input_disable <= 1'b1;
      channel_select <= 4'h0;
    end else if (wr_ok && req.idx == `ACL_IDX_CTRL1) begin
      operating_mode_field <=
        req.wdata[`ACL_C1_MODE_HI:`ACL_C1_MODE_LO];
      input_disable <= req.wdata[`ACL_C1_INDIS];
      channel_select <= req.wdata[`ACL_C1_CH_HI:0];
    end
  end

  // start bit: write sets it, beginning a conversion clears it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      conversion_start_bit <= 1'b0;
    end else if (standby || start_now) begin
      conversion_start_bit <= 1'b0;
    end else if (wr_ok && req.idx == `ACL_IDX_CTRL1) begin
      conversion_start_bit <= req.wdata[`ACL_C1_START];
    end
  end

  // timing and ladder control
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      timing_ctrl <= 6'(`ACL_RST_CTRL2);
    end else if (standby) begin
      timing_ctrl <= 6'h00;
    end else if (wr_ok && req.idx == `ACL_IDX_CTRL2) begin
      timing_ctrl <= req.wdata[`ACL_C2_KEEP_HI:0];
    end
  end

  // result capture; standby loses earlier results
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      conv_result_high <= `ACL_RST_RES;
      result_low <= 2'h0;
    end else if (standby) begin
      conv_result_high <= `ACL_RST_RES;
      result_low <= 2'h0;
    end else if (finish) begin
      conv_result_high <= converted_value[9:2];
      result_low <= converted_value[1:0];
    end
  end

  // end flag: completion wins over a clearing read or restart
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      end_of_conversion_flag <= 1'b0;
    end else if (finish) begin
      end_of_conversion_flag <= 1'b1;
    end else if (read_high || start_now || standby) begin
      end_of_conversion_flag <= 1'b0;
    end
  end

  // busy stays high across repeat-mode restarts
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      conversion_busy_flag <= 1'b0;
    end else begin
      conversion_busy_flag <=
        next_state == acl_pkg::ACL_ST_CONV;
    end
  end

  // sticky done status, write one to clear, set wins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_status <= 1'b0;
      irq_mask <= 1'b0;
    end else begin
      if (finish) begin
        irq_status <= 1'b1;
      end else if (req.wr && req.idx == `ACL_IDX_IRQ_STAT
          && req.wdata[0]) begin
        irq_status <= 1'b0;
      end
      if (req.wr && req.idx == `ACL_IDX_IRQ_MASK) begin
        irq_mask <= req.wdata[0];
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      conversion_done_irq <= 1'b0;
    end else begin
      conversion_done_irq <= irq_status && irq_mask;
    end
  end

  // analog controls; upper channel codes are reserved, low bits used
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      analog_ctrl <= '0;
      analog_ctrl.input_disable <= 1'b1;
    end else begin
      analog_ctrl.channel <= channel_select[2:0];
      analog_ctrl.input_disable <= input_disable;
      analog_ctrl.ladder_connect <= timing_ctrl[`ACL_C2_LADDER]
        || next_state == acl_pkg::ACL_ST_CONV;
      analog_ctrl.sample_start <= start_now || restart;
    end
  end

  // read mux; top bits of the timing register read as zero
  always_comb begin
    rsp.hit = 1'b1;
    rsp.rdata = 8'h00;
    case (req.idx)
      `ACL_IDX_CTRL1: rsp.rdata = {conversion_start_bit,
        operating_mode_field, input_disable, channel_select};
      `ACL_IDX_CTRL2: rsp.rdata = {2'h0, timing_ctrl};
      `ACL_IDX_RES_HI: rsp.rdata = conv_result_high;
      `ACL_IDX_RES_LO: rsp.rdata = {result_low,
        end_of_conversion_flag, conversion_busy_flag, 4'h0};
      `ACL_IDX_IRQ_STAT: rsp.rdata = {7'h00, irq_status};
      `ACL_IDX_IRQ_MASK: rsp.rdata = {7'h00, irq_mask};
      default: rsp.hit = 1'b0;
    endcase
  end
endmodule // acl_control

// ### test/acl_control_monitor.sv
// bus timing and analog control checker for the converter control logic
`include "acl_consts.svh"
module acl_control_monitor (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // write channels
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  // read channels
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  // power and analog side
  input wire acl_pkg::acl_pwr_type power_mode,
  input wire acl_pkg::acl_ana_type analog_ctrl
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // three cycles so the registered reset has landed
  sequence standby_held;
    (power_mode != acl_pkg::ACL_PWR_RUN) [*3];
  endsequence

  write_answer_a: assert property (
    wr_taken |-> !s_axi_bvalid ##2 s_axi_bvalid)
    else $error("write response not two cycles after request");
  // strobe then registered data; one more cycle if a write strobe wins
  read_answer_a: assert property (
    rd_taken |-> !s_axi_rvalid ##[3:4] s_axi_rvalid)
    else $error("read data not three or four cycles after request");
  write_okay_a: assert property (
    s_axi_bvalid |-> s_axi_bresp == `ACL_RESP_OKAY)
    else $error("write response not okay");
  write_busy_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready high with response pending");
  read_busy_a: assert property (rd_taken |=> !s_axi_arready [*2])
    else $error("read ready high with read pending");
  rdata_upper_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  ladder_conv_a: assert property (
    analog_ctrl.sample_start |-> analog_ctrl.ladder_connect)
    else $error("ladder not connected at conversion start");
  standby_reset_a: assert property (
    standby_held |-> analog_ctrl.input_disable
      && analog_ctrl.channel == 3'h0)
    else $error("analog control not reset in standby");
  standby_start_a: assert property (
    standby_held |-> !analog_ctrl.sample_start)
    else $error("conversion started in standby");
  start_pulse_a: assert property (
    $rose(analog_ctrl.sample_start) |=> !analog_ctrl.sample_start)
    else $error("start pulse longer than one cycle");
endmodule // acl_control_monitor

bind acl_control acl_control_monitor mon_u (.clock, .rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .power_mode,
  .analog_ctrl);

// ### test/adc_control_logic_tb.sv
// self-checking bench for the converter control logic
`include "acl_consts.svh"
module adc_control_logic_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [9:0] awaddr = 10'h000, araddr = 10'h000, cv = 10'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic bready = 1'b0, rready = 1'b0, irq_d = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h1;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata;
  logic [7:0] d;
  logic [2:0] ch;
  acl_pkg::acl_pwr_type power_mode = acl_pkg::ACL_PWR_RUN;
  acl_pkg::acl_ana_type ana;
  int n_fail = 0, n_tests = 0, cnt = 0, len = 0;
  logic [10:0] times [6] = '{`ACL_T_39, `ACL_T_78, `ACL_T_156, `ACL_T_312,
    `ACL_T_624, `ACL_T_1248};
  logic [2:0] codes [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};

  always #50 clock = ~clock;

  acl_control dut_u (.clock(clock), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .power_mode(power_mode), .converted_value(cv),
    .analog_ctrl(ana), .conversion_done_irq(irq));

  // cycles from the start pulse to the interrupt rise
  always @(posedge clock) begin
    cnt <= ana.sample_start ? 1 : cnt + 1;
    irq_d <= irq;
    if (irq && !irq_d) len <= cnt;
  end

  task fail(input string m);
    n_fail++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) fail($sformatf("got %h expected %h", got, exp));
  endtask

  task wr(input logic [7:0] idx, input logic [7:0] v);
    int t;
    t = 0;
    @(posedge clock);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      t++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && t < 100);
    bready <= 1'b0;
    if (bvalid !== 1'b1) fail("write timeout");
  endtask

  task rd(input logic [7:0] idx, output logic [7:0] v, output logic [1:0] rs);
    int t;
    t = 0;
    @(posedge clock);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      t++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && t < 100);
    rready <= 1'b0;
    v = rdata[7:0];
    rs = rresp;
    if (rvalid !== 1'b1) fail("read timeout");
  endtask

  task rchk(input logic [7:0] idx, input logic [7:0] exp);
    rd(idx, d, r);
    chk(16'(d), 16'(exp));
  endtask

  task wait_irq;
    int t;
    t = 0;
    do begin
      @(posedge clock);
      t++;
    end while (irq !== 1'b1 && t < 3000);
    if (irq !== 1'b1) fail("no interrupt");
  endtask

  task end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clock);
    fail("watchdog expired");
    end_of_test;
  end

  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    rchk(`ACL_IDX_CTRL1, `ACL_RST_CTRL1);
    rchk(`ACL_IDX_CTRL2, `ACL_RST_CTRL2);
    rchk(`ACL_IDX_RES_HI, `ACL_RST_RES);
    rd(8'h40, d, r);
    chk(16'(r), 16'(`ACL_RESP_SLVERR));
    wr(`ACL_IDX_CTRL2, 8'hff);
    rchk(`ACL_IDX_CTRL2, 8'h3f);
    chk(16'(ana.ladder_connect), 16'h1);
    wr(`ACL_IDX_IRQ_MASK, 8'h01);
    for (int i = 0; i < 6; i++) begin
      ch = 3'(i * 3);
      cv <= 10'h2c6 - 10'(i * 83);
      wr(`ACL_IDX_CTRL2, {4'h1, codes[i], 1'b0});
      wr(`ACL_IDX_CTRL1, {3'b101, 1'b0, 1'b0, ch});
      rchk(`ACL_IDX_CTRL1, {3'b001, 2'b00, ch});
      chk(16'(ana.channel), 16'(ch));
      chk(16'(ana.input_disable), 16'h0);
      rd(`ACL_IDX_RES_LO, d, r);
      chk(16'(d[5:4]), 16'h1);
      wait_irq;
      rd(`ACL_IDX_RES_LO, d, r);
      chk(16'(d), 16'({cv[1:0], 6'h20}));
      chk(16'(len), 16'(times[i]) + 16'h1);
      rchk(`ACL_IDX_RES_HI, cv[9:2]);
      rd(`ACL_IDX_RES_LO, d, r);
      chk(16'(d[5]), 16'h0);
      rchk(`ACL_IDX_IRQ_STAT, 8'h01);
      wr(`ACL_IDX_IRQ_STAT, 8'h01);
      rchk(`ACL_IDX_IRQ_STAT, 8'h00);
      chk(16'(irq), 16'h0);
    end
    chk(16'(ana.ladder_connect), 16'h0);
    // masked: status sticks, output stays low
    wr(`ACL_IDX_IRQ_MASK, 8'h00);
    wr(`ACL_IDX_CTRL1, 8'ha0);
    // longest time code is still selected: wait out 1248 cycles
    repeat (1300) @(posedge clock);
    chk(16'(irq), 16'h0);
    rchk(`ACL_IDX_IRQ_STAT, 8'h01);
    wr(`ACL_IDX_IRQ_STAT, 8'h01);
    // repeat mode keeps converting until the mode field is cleared
    wr(`ACL_IDX_CTRL2, 8'h18);
    wr(`ACL_IDX_CTRL1, 8'he0);
    repeat (700) @(posedge clock);
    rd(`ACL_IDX_RES_LO, d, r);
    chk(16'(d[5:4]), 16'h3);
    wr(`ACL_IDX_CTRL1, 8'h10);
    rd(`ACL_IDX_RES_LO, d, r);
    chk(16'(d[4]), 16'h0);
    rchk(`ACL_IDX_IRQ_STAT, 8'h01);
    wr(`ACL_IDX_IRQ_STAT, 8'h01);
    for (int p = 1; p < 4; p++) begin
      wr(`ACL_IDX_CTRL2, 8'h1c);
      wr(`ACL_IDX_CTRL1, 8'ha3);
      power_mode <= acl_pkg::acl_pwr_type'(p);
      repeat (3) @(posedge clock);
      rchk(`ACL_IDX_CTRL1, `ACL_RST_CTRL1);
      rchk(`ACL_IDX_CTRL2, `ACL_RST_CTRL2);
      wr(`ACL_IDX_CTRL1, 8'h25);
      rchk(`ACL_IDX_CTRL1, `ACL_RST_CTRL1);
      rd(`ACL_IDX_RES_LO, d, r);
      chk(16'(d[5:4]), 16'h0);
      power_mode <= acl_pkg::ACL_PWR_RUN;
    end
    end_of_test;
  end
endmodule // adc_control_logic_tb
